/* File: core/ieme_consts.svh */
// constants for the extended interrupt enable register
`ifndef IEME_CONSTS_SVH
`define IEME_CONSTS_SVH
`define IEME_REG_ADDR 8'hE6
`define IEME_REG_RESET 8'h00
`define IEME_BIT_TIMER3 7
`define IEME_BIT_COMP1 6
`define IEME_BIT_COMP0 5
`define IEME_BIT_COUNTER 4
`define IEME_BIT_ADC_DONE 3
`define IEME_BIT_ADC_WINDOW 2
`define IEME_BIT_ALARM 1
`define IEME_BIT_TWOWIRE 0
`endif

/* File: core/ieme_pkg.sv */
// types and shared decode for the extended interrupt enable register
package ieme_pkg;
  typedef logic [7:0] ieme_byte_t;

  // true when the special-function address selects this register (all pages)
  function automatic logic ieme_hit(input ieme_byte_t addr, input ieme_byte_t reg_addr);
    ieme_hit = (addr == reg_addr);
  endfunction
endpackage

/* File: core/ieme_sfr_reg.sv */
// special-function register slice holding the eight enable bits
`timescale 1ns/1ns
`default_nettype none
`include "ieme_consts.svh"
module ieme_sfr_reg
  import ieme_pkg::*;
(
  input wire logic mclk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic [7:0] sfr_addr, // register address
  input wire logic sfr_wr, // write strobe
  input wire logic sfr_rd, // read strobe
  input wire logic [7:0] sfr_wdata, // write data
  output ieme_byte_t enable, // stored enable bits
  output ieme_byte_t sfr_rdata // read data, zero when not selected
);
  logic wr_hit;
  logic rd_hit;

  assign wr_hit = sfr_wr && ieme_hit(sfr_addr, `IEME_REG_ADDR);
  assign rd_hit = sfr_rd && ieme_hit(sfr_addr, `IEME_REG_ADDR);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      enable <= `IEME_REG_RESET; // R6
    end else if (wr_hit) begin
      enable <= sfr_wdata; // R6
    end
  end

  // read returns the value held before any write in the same cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata <= 8'h00;
    end else if (rd_hit) begin
      sfr_rdata <= enable; // R6
    end else begin
      sfr_rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

/* File: core/ieme_sfr_reg_end.sv */
// (intentionally minimal) no further logic
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* File: core/ieme_top.sv */
// extended interrupt enable register with per-source request gating
//
// How it works
// R1: bit 6 passes comparator 1 rise or fall requests, else blocks them.
// R2: bit 5 passes comparator 0 rise or fall requests, else masks them.
// R3: bit 3 forwards the ADC conversion-done interrupt, else suppresses it.
// R4: bit 2 forwards the ADC window-compare interrupt, else suppresses it.
// R5: bit 1 forwards clock alarm match requests, else blocks them.
// R6: bits 7,4,0 gate timer 3, counter array, two-wire; all read/write, reset 0.
`timescale 1ns/1ns
`default_nettype none
`include "ieme_consts.svh"
module ieme_top
  import ieme_pkg::*;
(
  input wire logic mclk, // system clock, 25 MHz
  input wire logic rst_b, // async reset, active low
  input wire logic [7:0] sfr_addr, // register address
  input wire logic sfr_wr, // write strobe
  input wire logic sfr_rd, // read strobe
  input wire logic [7:0] sfr_wdata, // write data
  output ieme_byte_t sfr_rdata, // read data
  input wire logic timer3_low_overflow_flag, // timer 3 low byte overflow
  input wire logic timer3_high_overflow_flag, // timer 3 high byte overflow
  input wire logic comparator1_rise_flag, // comparator 1 rising edge
  input wire logic comparator1_fall_flag, // comparator 1 falling edge
  input wire logic comparator0_rise_flag, // comparator 0 rising edge
  input wire logic comparator0_fall_flag, // comparator 0 falling edge
  input wire logic counter_array_flag, // counter array request
  input wire logic adc_conversion_done_flag, // adc conversion complete
  input wire logic adc_window_match_flag, // adc window compare
  input wire logic clock_alarm_flag, // calendar clock alarm match
  input wire logic twowire_flag, // two-wire bus request
  output logic timer3_irq_req, // gated request to core
  output logic comparator1_irq_req, // gated request to core
  output logic comparator0_irq_req, // gated request to core
  output logic counter_array_irq_req, // gated request to core
  output logic adc_done_irq_req, // gated request to core
  output logic adc_window_irq_req, // gated request to core
  output logic clock_alarm_irq_req, // gated request to core
  output logic twowire_irq_req // gated request to core
);
  // ****************************************
  // register
  // ****************************************
  ieme_byte_t enable;
  logic timer3_irq_enable;
  logic comparator1_irq_enable;
  logic comparator0_irq_enable;
  logic counter_array_irq_enable;
  logic adc_done_irq_enable;
  logic adc_window_irq_enable;
  logic clock_alarm_irq_enable;
  logic twowire_irq_enable;

  ieme_sfr_reg u_reg (
    .mclk(mclk),
    .rst_b(rst_b),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata),
    .enable(enable),
    .sfr_rdata(sfr_rdata)
  );

  assign timer3_irq_enable = enable[`IEME_BIT_TIMER3];
  assign comparator1_irq_enable = enable[`IEME_BIT_COMP1];
  assign comparator0_irq_enable = enable[`IEME_BIT_COMP0];
  assign counter_array_irq_enable = enable[`IEME_BIT_COUNTER];
  assign adc_done_irq_enable = enable[`IEME_BIT_ADC_DONE];
  assign adc_window_irq_enable = enable[`IEME_BIT_ADC_WINDOW];
  assign clock_alarm_irq_enable = enable[`IEME_BIT_ALARM];
  assign twowire_irq_enable = enable[`IEME_BIT_TWOWIRE];

  // ****************************************
  // request gating
  // ****************************************
  // sources are flags on this clock, so no synchroniser; one cycle of latency
  // keeps every output on a flop at the cost of a cycle of response time
  logic timer3_any;
  logic comparator1_any;
  logic comparator0_any;

  assign timer3_any = timer3_low_overflow_flag || timer3_high_overflow_flag;
  assign comparator1_any = comparator1_rise_flag || comparator1_fall_flag;
  assign comparator0_any = comparator0_rise_flag || comparator0_fall_flag;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      comparator1_irq_req <= 1'b0;
      comparator0_irq_req <= 1'b0;
    end else begin
      comparator1_irq_req <= comparator1_irq_enable && comparator1_any; // R1
      comparator0_irq_req <= comparator0_irq_enable && comparator0_any; // R2
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      adc_done_irq_req <= 1'b0;
      adc_window_irq_req <= 1'b0;
    end else begin
      adc_done_irq_req <= adc_done_irq_enable && adc_conversion_done_flag; // R3
      adc_window_irq_req <= adc_window_irq_enable && adc_window_match_flag; // R4
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      clock_alarm_irq_req <= 1'b0;
    end else begin
      clock_alarm_irq_req <= clock_alarm_irq_enable && clock_alarm_flag; // R5
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      timer3_irq_req <= 1'b0;
      counter_array_irq_req <= 1'b0;
      twowire_irq_req <= 1'b0;
    end else begin
      timer3_irq_req <= timer3_irq_enable && timer3_any; // R6
      counter_array_irq_req <= counter_array_irq_enable && counter_array_flag; // R6
      twowire_irq_req <= twowire_irq_enable && twowire_flag; // R6
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  logic reg_wr_hit;
  logic reg_rd_hit;
  assign reg_wr_hit = sfr_wr && ieme_hit(sfr_addr, `IEME_REG_ADDR);
  assign reg_rd_hit = sfr_rd && ieme_hit(sfr_addr, `IEME_REG_ADDR);

  sequence comp1_open_s;
    comparator1_irq_enable && comparator1_any;
  endsequence
  sequence comp1_shut_s;
    !comparator1_irq_enable;
  endsequence
  sequence comp0_open_s;
    comparator0_irq_enable && comparator0_any;
  endsequence
  sequence comp0_shut_s;
    !comparator0_irq_enable;
  endsequence
  // a write of a new value followed by a source event gates on that value
  sequence wr_then_flag_s;
    reg_wr_hit && !sfr_wdata[`IEME_BIT_ADC_DONE] ##1 adc_conversion_done_flag;
  endsequence
  // an enabling write, then an alarm match one cycle later
  sequence alarm_on_s;
    reg_wr_hit && sfr_wdata[`IEME_BIT_ALARM];
  endsequence
  sequence alarm_match_s;
    clock_alarm_flag;
  endsequence

  comp1_pass_a: assert property (comp1_open_s |=> comparator1_irq_req) // R1
    else $error("comparator 1 request not passed");
  comp1_block_a: assert property (comp1_shut_s |=> !comparator1_irq_req) // R1
    else $error("comparator 1 request leaked while disabled");
  comp1_fall_a: assert property ( // R1
    comparator1_irq_enable && comparator1_fall_flag |=> comparator1_irq_req)
    else $error("comparator 1 fall request not passed");
  comp0_pass_a: assert property (comp0_open_s |=> comparator0_irq_req) // R2
    else $error("comparator 0 request not passed");
  comp0_block_a: assert property (comp0_shut_s |=> !comparator0_irq_req) // R2
    else $error("comparator 0 request leaked while disabled");
  comp0_fall_a: assert property ( // R2
    comparator0_irq_enable && comparator0_fall_flag |=> comparator0_irq_req)
    else $error("comparator 0 fall request not passed");

  adc_done_gate_a: assert property ( // R3
    adc_done_irq_req == ($past(adc_done_irq_enable) && $past(adc_conversion_done_flag)))
    else $error("adc done request does not follow its gate");
  adc_done_wr_a: assert property (wr_then_flag_s |=> !adc_done_irq_req) // R3
    else $error("adc done request passed after disabling write");
  adc_done_block_a: assert property (!adc_done_irq_enable |=> !adc_done_irq_req) // R3
    else $error("adc done request leaked while disabled");
  adc_win_gate_a: assert property ( // R4
    adc_window_irq_req |-> $past(adc_window_irq_enable) && $past(adc_window_match_flag))
    else $error("adc window request without enabled cause");
  adc_win_pass_a: assert property ( // R4
    adc_window_irq_enable && adc_window_match_flag |=> adc_window_irq_req)
    else $error("adc window request not forwarded");
  adc_win_block_a: assert property (!adc_window_irq_enable |=> !adc_window_irq_req) // R4
    else $error("adc window request leaked while disabled");

  alarm_gate_a: assert property ( // R5
    clock_alarm_irq_req == ($past(clock_alarm_irq_enable) && $past(clock_alarm_flag)))
    else $error("clock alarm request does not follow its gate");
  alarm_wr_a: assert property (alarm_on_s ##1 alarm_match_s |=> clock_alarm_irq_req) // R5
    else $error("clock alarm request missing after enabling write");
  alarm_block_a: assert property (!clock_alarm_irq_enable |=> !clock_alarm_irq_req) // R5
    else $error("clock alarm request leaked while disabled");

  timer3_gate_a: assert property ( // R6
    timer3_irq_req == ($past(timer3_irq_enable) && $past(timer3_any)))
    else $error("timer 3 request does not follow its gate");
  timer3_low_a: assert property ( // R6
    timer3_irq_enable && timer3_low_overflow_flag |=> timer3_irq_req)
    else $error("timer 3 low byte request not passed");
  timer3_high_a: assert property ( // R6
    timer3_irq_enable && timer3_high_overflow_flag |=> timer3_irq_req)
    else $error("timer 3 high byte request not passed");
  other_gate_a: assert property ( // R6
    counter_array_irq_req == ($past(counter_array_irq_enable) && $past(counter_array_flag)) &&
    twowire_irq_req == ($past(twowire_irq_enable) && $past(twowire_flag)))
    else $error("counter array or two-wire request wrong");
  reg_write_a: assert property (reg_wr_hit |=> enable == $past(sfr_wdata)) // R6
    else $error("enable register did not take write data");
  reg_hold_a: assert property (!reg_wr_hit |=> enable == $past(enable)) // R6
    else $error("enable register changed without a write");
  // a read in the cycle of a write must still return the value held before it
  reg_read_a: assert property (reg_rd_hit |=> sfr_rdata == $past(enable)) // R6
    else $error("read data differs from enable register");
  reg_unmapped_a: assert property (!reg_rd_hit |=> sfr_rdata == 8'h00) // R6
    else $error("read data not zero when not selected");
endmodule
`default_nettype wire

/* File: tb/ieme_src_model.sv */
// behavioural model of the peripheral flag sources that feed the enable register
`timescale 1ns/1ns
`default_nettype none
module ieme_src_model (
  input wire logic [10:0] pattern, // flag levels requested by the bench
  output logic [10:0] flags // flag levels seen by the enable register
);
  // flags are plain levels that follow the bench pattern directly, with no holding or clearing
  assign flags = pattern;
endmodule
`default_nettype wire

/* File: tb/ieme_top_tb_top.sv */
// self-checking testbench for the extended interrupt enable register
`timescale 1ns/1ns
`default_nettype none
module ieme_top_tb_top;
  import ieme_pkg::*;
  logic mclk, rst_b, sfr_wr, sfr_rd;
  logic [7:0] sfr_addr, sfr_wdata, m_en, m_rd, m_req, src;
  logic [10:0] pat;
  logic [31:0] r;
  wire [10:0] f;
  wire [7:0] req;
  ieme_byte_t sfr_rdata;
  integer fails = 0, compares = 0, seed = 42, i;
  wire t3, c1, c0, ca, ad, wn, al, tw;

  // ***************
  // clock and parts
  // ***************
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  ieme_src_model partner (.pattern(pat), .flags(f));

  ieme_top dut (.mclk(mclk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .timer3_low_overflow_flag(f[10]), .timer3_high_overflow_flag(f[9]),
    .comparator1_rise_flag(f[8]), .comparator1_fall_flag(f[7]),
    .comparator0_rise_flag(f[6]), .comparator0_fall_flag(f[5]),
    .counter_array_flag(f[4]), .adc_conversion_done_flag(f[3]),
    .adc_window_match_flag(f[2]), .clock_alarm_flag(f[1]), .twowire_flag(f[0]),
    .timer3_irq_req(t3), .comparator1_irq_req(c1), .comparator0_irq_req(c0),
    .counter_array_irq_req(ca), .adc_done_irq_req(ad), .adc_window_irq_req(wn),
    .clock_alarm_irq_req(al), .twowire_irq_req(tw));
  assign req = {t3, c1, c0, ca, ad, wn, al, tw};

  // ***************
  // reference model
  // ***************
  // paired sources are merged first so that either edge flag alone must pass
  always_comb src = {f[10] | f[9], f[8] | f[7], f[6] | f[5], f[4:0]};

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      m_en <= 8'h00;
      m_rd <= 8'h00;
      m_req <= 8'h00;
    end else begin
      m_req <= m_en & src;
      m_rd <= (sfr_rd && sfr_addr == 8'hE6) ? m_en : 8'h00;
      if (sfr_wr && sfr_addr == 8'hE6) m_en <= sfr_wdata;
    end
  end

  // ***************
  // tasks
  // ***************
  task check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task print_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // one cycle: compare what the last edge produced, then drive the next request
  task cyc(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d,
           input logic [10:0] p);
    @(negedge mclk);
    check(sfr_rdata, m_rd);
    check(req, m_req);
    sfr_wr = wr;
    sfr_rd = rd;
    sfr_addr = a;
    sfr_wdata = d;
    pat = p;
  endtask

  // ***************
  // stimulus
  // ***************
  initial begin
    #400000;
    fails++;
    print_verdict;
  end

  initial begin
    rst_b = 1'b0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    pat = 11'h000;
    repeat (3) @(posedge mclk);
    @(negedge mclk) rst_b = 1'b1;
    cyc(1'b0, 1'b1, 8'hE6, 8'h00, 11'h7FF);
    // each enable bit alone with every source raised
    for (i = 0; i < 8; i++) begin
      cyc(1'b1, 1'b0, 8'hE6, 8'h01 << i, 11'h7FF);
      cyc(1'b0, 1'b1, 8'hE6, 8'h00, 11'h7FF);
      cyc(1'b0, 1'b0, 8'h00, 8'h00, 11'h000);
    end
    // random traffic: single edge flags, stray addresses, read and write together
    for (i = 0; i < 600; i++) begin
      r = $random(seed);
      cyc(r[0], r[1], r[2] ? 8'hE6 : r[15:8], r[23:16], 11'($random(seed)));
    end
    // reset in mid-run must clear the enables again: fill them, idle the bus, then reset
    cyc(1'b1, 1'b0, 8'hE6, 8'hFF, 11'h7FF);
    cyc(1'b0, 1'b0, 8'h00, 8'h00, 11'h7FF);
    cyc(1'b0, 1'b0, 8'h00, 8'h00, 11'h7FF);
    @(negedge mclk) rst_b = 1'b0;
    @(negedge mclk);
    check(sfr_rdata, 8'h00);
    check(req, 8'h00);
    rst_b = 1'b1;
    cyc(1'b0, 1'b1, 8'hE6, 8'h00, 11'h7FF);
    cyc(1'b0, 1'b0, 8'h00, 8'h00, 11'h000);
    print_verdict;
  end
endmodule
`default_nettype wire
